// ---- hw/ocpwm_pkg.sv ----
package ocpwm_pkg;

    // Register port geometry.
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;

    // Register word addresses on the plain register port.
    localparam logic [2:0] OFS_CON1 = 3'h0;
    localparam logic [2:0] OFS_CON2 = 3'h1;
    localparam logic [2:0] OFS_PRI = 3'h2;
    localparam logic [2:0] OFS_SEC = 3'h3;
    localparam logic [2:0] OFS_TMR = 3'h4;
    localparam logic [2:0] OFS_STAT = 3'h5;

    // Field positions in compare_control_reg_one.
    localparam int CON1_TBSEL_LSB = 10;
    localparam int CON1_TCLR_BIT = 3;
    localparam int CON1_MODE_LSB = 0;
    // Field positions in compare_control_reg_two.
    localparam int CON2_CASC_BIT = 8;
    localparam int CON2_TRIG_BIT = 7;
    localparam int CON2_TSTAT_BIT = 6;
    localparam int CON2_SYNC_LSB = 0;
    // Field positions in the status register.
    localparam int STAT_IRQ_BIT = 0;
    localparam int STAT_PIN_BIT = 1;
    localparam int STAT_ST_LSB = 2;

    // Time base sources: five timer ticks plus the system clock.
    localparam int TB_TICKS = 5;
    localparam logic [2:0] TB_SYSCLK = 3'h7;
    localparam logic [2:0] TB_LAST_TIMER = 3'h4;

    // Sync source codes and counter limits.
    localparam logic [4:0] SYNC_NONE = 5'h00;
    localparam logic [4:0] SYNC_SELF = 5'h1f;
    localparam logic [15:0] TMR_MAX = 16'hffff;
    localparam logic [15:0] TMR_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_SS_HI = 3'h1,
        MODE_SS_LO = 3'h2,
        MODE_TOGGLE = 3'h3,
        MODE_DBL_SS = 3'h4,
        MODE_DBL_CONT = 3'h5,
        MODE_PWM_EDGE = 3'h6,
        MODE_PWM_CTR = 3'h7
    } ocpwm_mode_t;

    // Gray coded along idle, armed, run, done.
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ARMED = 2'h1,
        ST_RUN = 2'h3,
        ST_DONE = 2'h2
    } ocpwm_state_t;

    typedef struct packed {
        logic [2:0] tbsel;
        logic trig_clr_mode;
        ocpwm_mode_t mode;
    } ocpwm_con1_t;

    typedef struct packed {
        logic cascade;
        logic trig_sel;
        logic [4:0] sync_sel;
    } ocpwm_con2_t;

    typedef struct packed {
        logic a;
        logic b;
        logic p;
    } ocpwm_match_t;

    localparam ocpwm_con1_t CON1_RST = '{tbsel: 3'h0, trig_clr_mode: 1'b0, mode: MODE_OFF};
    localparam ocpwm_con2_t CON2_RST = '{cascade: 1'b0, trig_sel: 1'b0, sync_sel: SYNC_NONE};
    localparam logic [15:0] CMP_RST = 16'h0000;

endpackage

// ---- hw/ocpwm_tick_sel.sv ----
`timescale 1ns/1ps
module ocpwm_tick_sel
    import ocpwm_pkg::*;
(
    input wire logic [2:0] tbsel_i,
    input wire logic [TB_TICKS-1:0] tb_tick_i,
    input wire logic casc_even_i,
    input wire logic casc_carry_i,
    output logic adv_o
);

    // Picks the count enable: partner carry in a cascade, else the chosen source.
    always_comb begin
        if (casc_even_i) begin
            adv_o = casc_carry_i;
        end else if (tbsel_i == TB_SYSCLK) begin
            adv_o = 1'b1;
        end else if (tbsel_i <= TB_LAST_TIMER) begin
            adv_o = tb_tick_i[tbsel_i];
        end else begin
            adv_o = 1'b0;
        end
    end

endmodule

// ---- hw/ocpwm_match.sv ----
`timescale 1ns/1ps
module ocpwm_match
    import ocpwm_pkg::*;
(
    input wire logic [15:0] tmr_i,
    input wire logic [15:0] val_a_i,
    input wire logic [15:0] val_b_i,
    input wire logic [15:0] val_p_i,
    input wire logic adv_i,
    input wire logic casc_even_i,
    input wire logic casc_a_i,
    input wire logic casc_b_i,
    output ocpwm_match_t hit_o
);

    // A match counts once per count value; the high half's a and b matches take the low half's match in place of the count enable.
    always_comb begin
        hit_o.p = adv_i && (tmr_i == val_p_i);
        if (casc_even_i) begin
            hit_o.a = (tmr_i == val_a_i) && casc_a_i;
            hit_o.b = (tmr_i == val_b_i) && casc_b_i;
        end else begin
            hit_o.a = adv_i && (tmr_i == val_a_i);
            hit_o.b = adv_i && (tmr_i == val_b_i);
        end
    end

endmodule

// ---- hw/ocpwm_unit.sv ----
`timescale 1ns/1ps
module ocpwm_unit
    import ocpwm_pkg::*;
#(
    parameter bit EVEN_UNIT = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic [TB_TICKS-1:0] tb_tick_i,
    input wire logic [31:0] sync_evt_i,
    input wire logic casc_carry_i,
    input wire logic casc_pri_match_i,
    input wire logic casc_sec_match_i,
    output logic casc_carry_o,
    output logic casc_pri_match_o,
    output logic casc_sec_match_o,
    output logic comp_out_o,
    output logic comp_irq_flag_o
);

    ocpwm_con1_t con1_q;
    ocpwm_con2_t con2_q;
    logic [15:0] pri_q;
    logic [15:0] sec_q;
    logic [15:0] pri_buf_q;
    logic [15:0] sec_buf_q;
    logic [15:0] tmr_q;
    logic [15:0] tmr_d;
    logic [15:0] val_a;
    logic [15:0] val_b;
    logic [15:0] rd_mux;
    logic [15:0] rdata_q;
    ocpwm_state_t state_q;
    ocpwm_state_t state_d;
    ocpwm_match_t hit;
    logic trig_stat_q;
    logic irq_q;
    logic pin_q;
    logic pin_d;
    logic carry_q;
    logic pri_m_q;
    logic sec_m_q;
    logic wr_con1;
    logic wr_con2;
    logic wr_pri;
    logic wr_sec;
    logic wr_stat;
    logic casc_even;
    logic trig_mode;
    logic sync_mode;
    logic adv;
    logic src_evt;
    logic running;
    logic sync_rst;
    logic wrap;
    logic period_end;
    logic pwm_mode;
    logic single_mode;
    logic double_mode;
    logic load_buf;
    logic shot_fin;
    logic irq_evt;

    // Center-aligned edge: pulse of width duty centered in the period.
    function automatic logic [15:0] ctr_edge(input logic [15:0] per, input logic [15:0] duty,
                                             input logic fall);
        logic [15:0] rise;
        rise = (per >> 1) - (duty >> 1);
        ctr_edge = fall ? 16'(rise + duty) : rise;
    endfunction

    // Write strobes per register.
    assign wr_con1 = reg_we_i && (reg_addr_i == OFS_CON1);
    assign wr_con2 = reg_we_i && (reg_addr_i == OFS_CON2);
    assign wr_pri = reg_we_i && (reg_addr_i == OFS_PRI);
    assign wr_sec = reg_we_i && (reg_addr_i == OFS_SEC);
    assign wr_stat = reg_we_i && (reg_addr_i == OFS_STAT);

    // Mode decode.
    assign casc_even = EVEN_UNIT && con2_q.cascade;
    assign trig_mode = (con2_q.sync_sel != SYNC_NONE) && con2_q.trig_sel && !casc_even;
    assign sync_mode = (con2_q.sync_sel != SYNC_NONE) && !trig_mode;
    assign pwm_mode = con1_q.mode[2] && con1_q.mode[1];
    assign single_mode = !con1_q.mode[2] && (con1_q.mode != MODE_OFF);
    assign double_mode = (con1_q.mode == MODE_DBL_SS) || (con1_q.mode == MODE_DBL_CONT);
    assign running = (state_q == ST_RUN) || (state_q == ST_DONE);

    // Count enable from the selected time base.
    ocpwm_tick_sel u_tick (
        .tbsel_i(con1_q.tbsel),
        .tb_tick_i(tb_tick_i),
        .casc_even_i(casc_even),
        .casc_carry_i(casc_carry_i),
        .adv_o(adv)
    );

    // Compare points: center mode derives its edges from the buffered pair.
    assign val_a = (con1_q.mode == MODE_PWM_CTR) ? ctr_edge(sec_buf_q, pri_buf_q, 1'b0)
                                                 : pri_buf_q;
    assign val_b = (con1_q.mode == MODE_PWM_CTR) ? ctr_edge(sec_buf_q, pri_buf_q, 1'b1)
                                                 : sec_buf_q;

    ocpwm_match u_match (
        .tmr_i(tmr_q),
        .val_a_i(val_a),
        .val_b_i(val_b),
        .val_p_i(sec_buf_q),
        .adv_i(adv),
        .casc_even_i(casc_even),
        .casc_a_i(casc_pri_match_i),
        .casc_b_i(casc_sec_match_i),
        .hit_o(hit)
    );

    // Source event: own period match for code 1f, else the selected input.
    assign src_evt = (con2_q.sync_sel == SYNC_SELF) ? hit.p : sync_evt_i[con2_q.sync_sel];
    assign sync_rst = sync_mode && src_evt && running;
    assign wrap = running && adv && (tmr_q == TMR_MAX) && !sync_rst;
    assign period_end = sync_rst || wrap;

    // Counter: held at zero unless running, cleared by sync, else counts up.
    always_comb begin
        if (!running) begin
            tmr_d = TMR_ZERO;
        end else if (sync_rst) begin
            tmr_d = TMR_ZERO;
        end else if (adv) begin
            tmr_d = 16'(tmr_q + 16'h0001);
        end else begin
            tmr_d = tmr_q;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tmr_q <= TMR_ZERO;
        end else begin
            tmr_q <= tmr_d;
        end
    end

    // A single-shot ends on its last edge.
    assign shot_fin = hit.a && ((con1_q.mode == MODE_SS_HI) || (con1_q.mode == MODE_SS_LO))
                      || hit.b && (con1_q.mode == MODE_DBL_SS);

    // Run sequence: idle, armed (waiting for start), run, done.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (con1_q.mode != MODE_OFF) begin
                    state_d = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (con1_q.mode == MODE_OFF) begin
                    state_d = ST_IDLE;
                end else if (!trig_mode || trig_stat_q) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (con1_q.mode == MODE_OFF) begin
                    state_d = ST_IDLE;
                end else if (wr_con1 || (trig_mode && !trig_stat_q)) begin
                    state_d = ST_ARMED;
                end else if (shot_fin) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                if (con1_q.mode == MODE_OFF) begin
                    state_d = ST_IDLE;
                end else if (wr_con1) begin
                    state_d = ST_ARMED;
                end else if (trig_mode && !trig_stat_q) begin
                    state_d = ST_ARMED;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Output level per mode.
    always_comb begin
        pin_d = pin_q;
        case (state_q)
            ST_IDLE: begin
                pin_d = 1'b0;
            end
            ST_ARMED: begin
                pin_d = (con1_q.mode == MODE_SS_LO) ||
                        ((con1_q.mode == MODE_PWM_EDGE) && (pri_q != CMP_RST));
            end
            ST_RUN: begin
                case (con1_q.mode)
                    MODE_SS_HI: begin
                        if (hit.a) begin
                            pin_d = 1'b1;
                        end
                    end
                    MODE_SS_LO: begin
                        if (hit.a) begin
                            pin_d = 1'b0;
                        end
                    end
                    MODE_TOGGLE: begin
                        if (hit.a) begin
                            pin_d = ~pin_q;
                        end
                    end
                    MODE_DBL_SS, MODE_DBL_CONT, MODE_PWM_CTR: begin
                        if (hit.a) begin
                            pin_d = 1'b1;
                        end
                        if (hit.b) begin
                            pin_d = 1'b0;
                        end
                    end
                    MODE_PWM_EDGE: begin
                        if (hit.a) begin
                            pin_d = 1'b0;
                        end
                        if (period_end) begin
                            pin_d = (pri_q != CMP_RST);
                        end
                    end
                    default: begin
                        pin_d = pin_q;
                    end
                endcase
            end
            default: begin
                pin_d = pin_q;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
        end
    end

    // Software-visible control and compare registers.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            con1_q <= CON1_RST;
            con2_q <= CON2_RST;
            pri_q <= CMP_RST;
            sec_q <= CMP_RST;
        end else begin
            if (wr_con1) begin
                con1_q.tbsel <= reg_wdata_i[CON1_TBSEL_LSB +: 3];
                con1_q.trig_clr_mode <= reg_wdata_i[CON1_TCLR_BIT];
                con1_q.mode <= ocpwm_mode_t'(reg_wdata_i[CON1_MODE_LSB +: 3]);
            end
            if (wr_con2) begin
                con2_q.cascade <= reg_wdata_i[CON2_CASC_BIT];
                con2_q.trig_sel <= reg_wdata_i[CON2_TRIG_BIT];
                con2_q.sync_sel <= reg_wdata_i[CON2_SYNC_LSB +: 5];
            end
            if (wr_pri) begin
                pri_q <= reg_wdata_i;
            end
            if (wr_sec) begin
                sec_q <= reg_wdata_i;
            end
        end
    end

    // Hidden buffers follow the registers except while a PWM period runs.
    assign load_buf = !pwm_mode || !running || period_end;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pri_buf_q <= CMP_RST;
            sec_buf_q <= CMP_RST;
        end else if (load_buf) begin
            pri_buf_q <= pri_q;
            sec_buf_q <= sec_q;
        end
    end

    // Trigger status: hardware set wins over both clears.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            trig_stat_q <= 1'b0;
        end else if (trig_mode && src_evt) begin
            trig_stat_q <= 1'b1;
        end else if (wr_con2) begin
            trig_stat_q <= reg_wdata_i[CON2_TSTAT_BIT];
        end else if (con1_q.trig_clr_mode && hit.b && running) begin
            trig_stat_q <= 1'b0;
        end
    end

    // Interrupt flag: sticky, write one to clear, a new event wins.
    assign irq_evt = (state_q == ST_RUN) && ((single_mode && hit.a) ||
                     (double_mode && hit.b) || (pwm_mode && period_end));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else if (irq_evt) begin
            irq_q <= 1'b1;
        end else if (wr_stat && reg_wdata_i[STAT_IRQ_BIT]) begin
            irq_q <= 1'b0;
        end
    end

    // Cascade handoff to the partner unit, registered.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            carry_q <= 1'b0;
            pri_m_q <= 1'b0;
            sec_m_q <= 1'b0;
        end else begin
            carry_q <= wrap;
            pri_m_q <= hit.a;
            sec_m_q <= hit.b;
        end
    end

    // Read image of the addressed register.
    always_comb begin
        rd_mux = 16'h0000;
        case (reg_addr_i)
            OFS_CON1: begin
                rd_mux[CON1_TBSEL_LSB +: 3] = con1_q.tbsel;
                rd_mux[CON1_TCLR_BIT] = con1_q.trig_clr_mode;
                rd_mux[CON1_MODE_LSB +: 3] = con1_q.mode;
            end
            OFS_CON2: begin
                rd_mux[CON2_CASC_BIT] = con2_q.cascade;
                rd_mux[CON2_TRIG_BIT] = con2_q.trig_sel;
                rd_mux[CON2_TSTAT_BIT] = trig_stat_q;
                rd_mux[CON2_SYNC_LSB +: 5] = con2_q.sync_sel;
            end
            OFS_PRI: rd_mux = pri_q;
            OFS_SEC: rd_mux = sec_q;
            OFS_TMR: rd_mux = tmr_q;
            OFS_STAT: begin
                rd_mux[STAT_IRQ_BIT] = irq_q;
                rd_mux[STAT_PIN_BIT] = pin_q;
                rd_mux[STAT_ST_LSB +: 2] = state_q;
            end
            default: rd_mux = 16'h0000;
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= reg_re_i ? rd_mux : 16'h0000;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign comp_out_o = pin_q;
    assign comp_irq_flag_o = irq_q;
    assign casc_carry_o = carry_q;
    assign casc_pri_match_o = pri_m_q;
    assign casc_sec_match_o = sec_m_q;

    // Checks on the counter, output and flags.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    cnt_step_a: assert property (running && adv && !sync_rst |=>
        tmr_q == 16'($past(tmr_q) + 16'h0001)) else $error("counter did not step");
    sync_clear_a: assert property (sync_rst |=> tmr_q == TMR_ZERO)
        else $error("sync event did not clear counter");
    trig_hold_a: assert property (trig_mode && !trig_stat_q && !src_evt && !wr_con2
        |=> ##1 tmr_q == TMR_ZERO) else $error("counter ran before trigger");
    idle_low_a: assert property ((con1_q.mode == MODE_OFF && !wr_con1) [*2]
        |=> !comp_out_o) else $error("idle output not low");
    ss_rise_a: assert property (state_q == ST_RUN && con1_q.mode == MODE_SS_HI && hit.a
        && !wr_con1 |=> comp_out_o && state_q == ST_DONE) else $error("single shot did not fire");
    dbl_return_a: assert property (state_q == ST_RUN && double_mode && hit.b
        |=> !comp_out_o) else $error("double compare did not return");
    irq_set_a: assert property (irq_evt |=> comp_irq_flag_o)
        else $error("flag not set on event");
    shot_once_a: assert property (state_q == ST_DONE && !wr_con1 && con1_q.mode != MODE_OFF
        && !(trig_mode && !trig_stat_q) |=> state_q == ST_DONE && $stable(comp_out_o))
        else $error("single shot repeated");
    buf_hold_a: assert property (pwm_mode && running && !period_end
        |=> $stable(pri_buf_q) && $stable(sec_buf_q)) else $error("buffer changed mid period");
    trig_clear_a: assert property (con1_q.trig_clr_mode && hit.b && running && !wr_con2
        && !(trig_mode && src_evt) |=> !trig_stat_q) else $error("trigger status not cleared");

    pwm_period_c: cover property (pwm_mode && sync_rst ##1 tmr_q == TMR_ZERO);
    shot_done_c: cover property (state_q == ST_RUN ##1 state_q == ST_DONE);
    trig_start_c: cover property (state_q == ST_ARMED && trig_mode ##1 state_q == ST_RUN);

endmodule

// ---- bench/ocpwm_far_model.sv ----
`timescale 1ns/1ps
// Far side: a free timer on source zero, a trigger on event one, and the even cascade partner.
module ocpwm_far_model
    import ocpwm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fire_i,
    input wire logic [2:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic hi_we_i,
    input wire logic lo_carry_i,
    input wire logic lo_pri_i,
    input wire logic lo_sec_i,
    output logic hi_out_o,
    output logic [TB_TICKS-1:0] tick_o,
    output logic [31:0] evt_o
);
    // High half of a cascade pair; it counts the low unit's wraps.
    ocpwm_unit #(.EVEN_UNIT(1'b1)) i_hi (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr_i),
        .reg_wdata_i(wdata_i), .reg_we_i(hi_we_i), .reg_re_i(1'b0), .reg_rdata_o(),
        .tb_tick_i(tick_o), .sync_evt_i(32'h0), .casc_carry_i(lo_carry_i),
        .casc_pri_match_i(lo_pri_i), .casc_sec_match_i(lo_sec_i), .casc_carry_o(),
        .casc_pri_match_o(), .casc_sec_match_o(), .comp_out_o(hi_out_o),
        .comp_irq_flag_o());
    logic [1:0] div_q;
    // The timer divides by four and never stops, so each count on source zero takes four clocks.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end
    assign tick_o = {4'h0, div_q == 2'h3};
    // Trigger event one is a single clock pulse, one cycle after the request.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            evt_o <= 32'h0;
        end else begin
            evt_o <= {30'h0, fire_i, 1'b0};
        end
    end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import ocpwm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [15:0] wdata = 16'h0;
    logic we = 1'b0;
    logic re = 1'b0;
    logic fire = 1'b0;
    logic we_hi = 1'b0;
    logic carry;
    logic pm;
    logic sm;
    logic hi_out;
    logic [15:0] rdata;
    logic [4:0] tick;
    logic [31:0] evt;
    logic comp_out_o;
    logic flag;
    logic [15:0] d;
    int fail_count = 0;
    int total_checks = 0;
    int n, m, p, s;
    // The clock toggles every half period of 10 ns.
    always #10 clk_i = ~clk_i;
    ocpwm_unit i_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .tb_tick_i(tick), .sync_evt_i(evt),
        .casc_carry_i(1'b0), .casc_pri_match_i(1'b0), .casc_sec_match_i(1'b0),
        .casc_carry_o(carry), .casc_pri_match_o(pm), .casc_sec_match_o(sm),
        .comp_out_o(comp_out_o), .comp_irq_flag_o(flag));
    ocpwm_far_model i_far (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .addr_i(addr),
        .wdata_i(wdata), .hi_we_i(we_hi), .lo_carry_i(carry), .lo_pri_i(pm), .lo_sec_i(sm),
        .hi_out_o(hi_out), .tick_o(tick), .evt_o(evt));
    // Compares one value and counts it.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // One write cycle; returns at the edge that takes it.
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr <= a;
        wdata <= v;
        we <= 1'b1;
        @(posedge clk_i);
        we <= 1'b0;
    endtask
    // One write cycle to the even partner unit.
    task automatic wr_hi(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr <= a;
        wdata <= v;
        we_hi <= 1'b1;
        @(posedge clk_i);
        we_hi <= 1'b0;
    endtask
    // One read cycle; the data stand only in the following cycle.
    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge clk_i);
        addr <= a;
        re <= 1'b1;
        @(posedge clk_i);
        re <= 1'b0;
        #1;
        v = rdata;
    endtask
    // Counts edges until the pin reaches a level; a hang ends the run.
    task automatic wait_out(input logic lvl, input int bound, output int k);
        k = 0;
        #1;
        while (comp_out_o !== lvl && k < bound) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        if (k >= bound) begin
            fail_count++;
            $display("wrong value pin wait expected %h seen %h", lvl, comp_out_o);
            report_and_stop();
        end
    endtask
    // Main sequence; expected figures come from the compare values chosen here.
    initial begin
        p = $urandom(32'h3b90) % 8 + 2;
        s = p + $urandom() % 8 + 3;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_CON2, d);
        chk("sync default", 16'h0, d);
        rd(3'h6, d);
        chk("unmapped read", 16'h0, d);
        chk("idle pin", 16'h0, {15'h0, comp_out_o});
        wr(OFS_PRI, p[15:0]);
        wr(OFS_SEC, s[15:0]);
        wr(OFS_CON1, {3'h0, TB_SYSCLK, 7'h0, MODE_SS_HI});
        wait_out(1'b1, 40, n);
        chk("shot delay", 16'(p + 3), 16'(n));
        chk("shot flag", 16'h1, {15'h0, flag});
        chk("pri match out", 16'h1, {15'h0, pm});
        repeat (p + 20) @(posedge clk_i);
        chk("shot once", 16'h1, {15'h0, comp_out_o});
        rd(OFS_STAT, d);
        chk("shot state", 16'h2, {14'h0, d[3:2]});
        wr(OFS_STAT, 16'h1);
        rd(OFS_STAT, d);
        chk("flag clear", 16'h0, {15'h0, d[0]});
        wr(OFS_CON1, 16'h0);
        repeat (2) @(posedge clk_i);
        #1;
        chk("off pin", 16'h0, {15'h0, comp_out_o});
        wr_hi(OFS_CON2, 16'h0100);
        wr(OFS_CON2, 16'h0100);
        wr_hi(OFS_PRI, 16'h0001);
        wr_hi(OFS_CON1, {13'h0, MODE_TOGGLE});
        wr(OFS_PRI, 16'hffff);
        wr(OFS_CON1, {3'h0, TB_SYSCLK, 7'h0, MODE_TOGGLE});
        repeat (2) @(posedge clk_i);
        rd(OFS_TMR, d);
        m = d;
        repeat (10) @(posedge clk_i);
        rd(OFS_TMR, d);
        chk("count step", 16'(m + 12), d);
        n = 0;
        while (carry !== 1'b1 && n < 70000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (n >= 70000) begin
            fail_count++;
            report_and_stop();
        end
        chk("wrap carry", 16'(16'hffff - d), 16'(n));
        chk("wrap toggle", 16'h1, {15'h0, comp_out_o});
        wr(OFS_PRI, 16'(p + 8));
        repeat (p + 12) @(posedge clk_i);
        #1;
        chk("toggle back", 16'h0, {15'h0, comp_out_o});
        chk("cascade pin", 16'h1, {15'h0, hi_out});
        wr(OFS_STAT, 16'h1);
        wr(OFS_CON1, 16'h0);
        wr(OFS_PRI, p[15:0]);
        wr(OFS_CON1, {3'h0, 3'h0, 7'h0, MODE_DBL_SS});
        wait_out(1'b1, 400, n);
        chk("dbl rise flag", 16'h0, {15'h0, flag});
        wait_out(1'b0, 400, n);
        chk("dbl width", 16'((s - p) * 4), 16'(n));
        chk("dbl flag", 16'h1, {15'h0, flag});
        chk("sec match out", 16'h1, {15'h0, sm});
        wr(OFS_CON1, 16'h0);
        wr(OFS_CON1, {3'h0, TB_SYSCLK, 7'h0, MODE_SS_LO});
        wait_out(1'b1, 40, n);
        wait_out(1'b0, 40, n);
        chk("low shot", 16'(p + 1), 16'(n));
        wr(OFS_CON1, 16'h0);
        wr(OFS_CON2, {11'h0, SYNC_SELF});
        wr(OFS_CON1, {3'h0, TB_SYSCLK, 7'h0, MODE_PWM_EDGE});
        wait_out(1'b1, 400, n);
        wait_out(1'b0, 400, n);
        wait_out(1'b1, 400, m);
        wait_out(1'b0, 400, n);
        chk("pwm period", 16'(s + 1), 16'(n + m));
        wr(OFS_CON1, 16'h0);
        wr(OFS_CON2, {8'h0, 1'b1, 2'h0, 5'h01});
        wr(OFS_CON1, {3'h0, TB_SYSCLK, 6'h0, 1'b1, MODE_SS_HI});
        repeat (p + 10) @(posedge clk_i);
        rd(OFS_TMR, d);
        chk("held count", 16'h0, d);
        chk("held pin", 16'h0, {15'h0, comp_out_o});
        @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        wait_out(1'b1, 60, n);
        chk("trig pin", 16'h1, {15'h0, comp_out_o});
        chk("trig delay", 16'(p + 3), 16'(n));
        repeat (16) @(posedge clk_i);
        rd(OFS_CON2, d);
        chk("trig status clear", 16'h0, {15'h0, d[6]});
        chk("rearm pin", 16'h0, {15'h0, comp_out_o});
        report_and_stop();
    end
endmodule
